// [verilog/fsc_pkg.sv]
package fsc_pkg;
  // timing
  localparam int CLK_NS = 4;
  localparam int LINK_NS = 160;
  localparam int WRITE_REG_NS = 4000;
  localparam int PROGRAM_NS = 8000;
  localparam int ERASE_NS = 16000;
  localparam int BUSY_W = 12;
  localparam int SCLK_HALF_CYC = LINK_NS / (2 * CLK_NS);
  localparam int GAP_HALVES = 2;

  // opcodes
  localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
  localparam logic [7:0] PAGE_WRITE_CMD = 8'h02;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] READ_STATUS_CMD = 8'h05;
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] READ_CONFIG_CMD = 8'h15;
  localparam logic [7:0] FOUR_KIB_WIPE_CMD = 8'h20;
  localparam logic [7:0] ENTER_FOUR_WIRE_CMD = 8'h35;
  localparam logic [7:0] HALF_BLOCK_WIPE_CMD = 8'h52;
  localparam logic [7:0] CHIP_WIPE_CMD = 8'h60;
  localparam logic [7:0] BLOCK_WIPE_CMD = 8'hD8;
  localparam logic [7:0] EXIT_FOUR_WIRE_CMD = 8'hF5;

  // frame bit counts
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
  localparam logic [CNT_W-1:0] CMD_BITS = 6'h08;
  localparam logic [CNT_W-1:0] WSR_ONE_BITS = 6'h10;
  localparam logic [CNT_W-1:0] WSR_TWO_BITS = 6'h18;
  localparam logic [CNT_W-1:0] ADDR_END_BITS = 6'h20;
  localparam logic [CNT_W-1:0] STEP_SINGLE = 6'h01;
  localparam logic [CNT_W-1:0] STEP_QUAD = 6'h04;
  localparam int BYTE_LOG = 3;

  // status and configuration fields
  localparam int BUSY_BIT = 0;
  localparam int LATCH_BIT = 1;
  localparam int LEVEL_LSB = 2;
  localparam int QUAD_BIT = 6;
  localparam int LOCK_BIT = 7;
  localparam int DRIVE_LSB = 0;
  localparam int TB_BIT = 3;
  localparam int DUMMY_LSB = 6;
  localparam int FOUR_WIRE_POS = 16;
  localparam logic [3:0] LEVEL_RST = 4'h0;
  localparam logic [3:0] LEVEL_ALL = 4'h9;
  localparam logic [2:0] DRIVE_RST = 3'h7;
  localparam logic [1:0] DUMMY_RST = 2'h0;

  // array geometry: 64 KiB blocks
  localparam int BLOCK_LSB = 16;
  localparam logic [8:0] ARRAY_BLOCKS = 9'h100;

  // lane enables
  localparam logic [3:0] LANES_SINGLE_RD = 4'h2;
  localparam logic [3:0] LANES_QUAD = 4'hF;
  localparam logic [3:0] HOST_TX_SINGLE = 4'hD;
  localparam logic [3:0] HOST_RX_SINGLE = 4'hC;

  function automatic logic [BUSY_W-1:0] busy_cycles(input int ns);
    return BUSY_W'(ns / CLK_NS - 1);
  endfunction

  // fast-read dummy clocks from the two-bit code
  function automatic logic [3:0] dummy_clocks_of(input logic [1:0] dc);
    return (dc == 2'h1) ? 4'h6 : (dc == 2'h3) ? 4'hA : 4'h8;
  endfunction

  // lanes for output step idx, msb first
  function automatic logic [3:0] lane_bits(input logic [7:0] b, input logic [2:0] idx,
                                           input logic wide);
    logic [7:0] s;
    s = wide ? (idx[0] ? {b[3:0], 4'h0} : b) : (b << idx);
    return wide ? s[7:4] : {2'h0, s[7], 1'h0};
  endfunction

  function automatic logic is_protected(input logic [23:0] a, input logic [3:0] lvl,
                                        input logic bottom);
    logic [8:0] region;
    logic [8:0] blk;
    blk = {1'h0, a[BLOCK_LSB +: 8]};
    if (lvl == LEVEL_RST) region = 9'h000;
    else if (lvl >= LEVEL_ALL) region = ARRAY_BLOCKS;
    else region = 9'(9'h001 << (lvl - 4'h1));
    return bottom ? (blk < region) : (blk >= ARRAY_BLOCKS - region);
  endfunction
endpackage

// [verilog/fsc_link_if.sv]
`timescale 1ns/1ns
interface fsc_link_if;
  logic sclk;
  logic cs_n;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_out;
  logic [3:0] dev_io_oe;
  wire [3:0] io;

  // undriven lines pull high
  assign io = (host_io_oe & host_io_out) | (dev_io_oe & dev_io_out) |
              ~(host_io_oe | dev_io_oe);

  modport host(output sclk, output cs_n, output host_io_out, output host_io_oe, input io);
  modport device(input sclk, input cs_n, input io, output dev_io_out, output dev_io_oe);
endinterface

// [verilog/fsc_device.sv]
`timescale 1ns/1ns
module fsc_device
  import fsc_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // link
  fsc_link_if.device link,
  // register state
  output logic busy_flag,
  output logic write_latch_flag,
  output logic [3:0] protect_level,
  output logic quad_io_select,
  output logic status_lock,
  output logic protect_from_bottom,
  output logic [2:0] drive_strength,
  output logic [1:0] dummy_count,
  output logic [3:0] dummy_clocks,
  output logic four_wire_command_mode,
  output logic hardware_lock_mode
);
  localparam logic [BUSY_W-1:0] WRITE_REG_CYC = busy_cycles(WRITE_REG_NS);
  localparam logic [BUSY_W-1:0] PROGRAM_CYC = busy_cycles(PROGRAM_NS);
  localparam logic [BUSY_W-1:0] ERASE_CYC = busy_cycles(ERASE_NS);

  // ---- link clock domain ----
  logic frame_rst_b;
  logic [15:0] regs_m;
  logic [15:0] regs_s;
  logic in_frame;
  logic [CNT_W-1:0] cnt;
  logic [31:0] sh;
  logic [7:0] cmd;
  logic [7:0] rd_byte;
  logic [23:0] addr;
  logic [2:0] out_idx;
  logic [3:0] dev_out;
  logic [3:0] dev_oe;
  logic [15:0] regs_live;
  logic [BUSY_W-1:0] busy_cnt;

  assign frame_rst_b = rst_b & ~link.cs_n;

  // mode changes only while deselected and is settled before the next first link edge;
  // the two-stage image would still show the old mode on the first two edges of a frame
  wire wide = four_wire_command_mode;
  wire [CNT_W-1:0] step = wide ? STEP_QUAD : STEP_SINGLE;
  wire [CNT_W-1:0] base = in_frame ? cnt : '0;
  wire [CNT_W-1:0] next_cnt = (base > CNT_MAX - step) ? CNT_MAX : base + step;
  wire [31:0] next_sh = wide ? {sh[27:0], link.io} : {sh[30:0], link.io[0]};
  wire next_is_cfg = (next_sh[7:0] == READ_CONFIG_CMD);
  wire is_read = (cmd == READ_STATUS_CMD) || (cmd == READ_CONFIG_CMD);
  wire rd_active = in_frame && (cnt >= CMD_BITS) && is_read;

  // register image carried across to the link clock
  always_ff @(posedge link.sclk or negedge rst_b) begin
    if (!rst_b) begin
      regs_m <= '0;
      regs_s <= '0;
    end else begin
      regs_m <= regs_live;
      regs_s <= regs_m;
    end
  end

  // cleared by the frame's own deselect, no sclk edge needed
  always_ff @(posedge link.sclk or negedge frame_rst_b) begin
    if (!frame_rst_b) in_frame <= 1'b0;
    else in_frame <= 1'b1;
  end

  // capture stays put after deselect for the system side to decode
  always_ff @(posedge link.sclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
      sh <= '0;
      cmd <= '0;
      rd_byte <= '0;
      addr <= '0;
    end else begin
      cnt <= next_cnt;
      sh <= next_sh;
      if (next_cnt == CMD_BITS) begin
        cmd <= next_sh[7:0];
        rd_byte <= next_is_cfg ? regs_s[15:8] : regs_s[7:0];
      end
      if (next_cnt == ADDR_END_BITS) addr <= next_sh[23:0];
    end
  end

  // read data changes on the falling edge
  always_ff @(negedge link.sclk or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      out_idx <= '0;
      dev_out <= '0;
      dev_oe <= '0;
    end else if (rd_active) begin
      dev_out <= lane_bits(rd_byte, out_idx, wide);
      dev_oe <= wide ? LANES_QUAD : LANES_SINGLE_RD;
      out_idx <= out_idx + 1'b1;
    end
  end

  assign link.dev_io_out = dev_out;
  assign link.dev_io_oe = dev_oe;

  // ---- system clock domain ----
  logic cs_m;
  logic cs_s;
  logic cs_d;
  logic wp_m;
  logic wp_s;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      wp_m <= 1'b1;
      wp_s <= 1'b1;
    end else if (clk_en) begin
      cs_m <= link.cs_n;
      cs_s <= cs_m;
      cs_d <= cs_s;
      wp_m <= link.io[2];
      wp_s <= wp_m;
    end
  end

  wire frame_end = cs_s & ~cs_d;
  wire aligned = (cnt[BYTE_LOG-1:0] == '0);
  wire hw_lock = status_lock & ~wp_s & ~quad_io_select & ~four_wire_command_mode;
  wire may_write = write_latch_flag & ~busy_flag & aligned;
  wire two = (cnt == WSR_TWO_BITS);
  wire [7:0] s_byte = two ? sh[15:8] : sh[7:0];
  wire [7:0] c_byte = sh[7:0];
  wire wsr_ok = may_write && (cmd == WRITE_STATUS_CMD) && (two || cnt == WSR_ONE_BITS) &&
                !hw_lock;
  wire is_wipe = (cmd == FOUR_KIB_WIPE_CMD) || (cmd == HALF_BLOCK_WIPE_CMD) ||
                 (cmd == BLOCK_WIPE_CMD);
  wire addr_ok = !is_protected(addr, protect_level, protect_from_bottom);
  wire prog_ok = may_write && (cmd == PAGE_WRITE_CMD) && (cnt > ADDR_END_BITS) && addr_ok;
  wire wipe_ok = may_write && is_wipe && (cnt == ADDR_END_BITS) && addr_ok;
  wire chip_ok = may_write && (cmd == CHIP_WIPE_CMD) && (cnt == CMD_BITS) &&
                 (protect_level == LEVEL_RST);
  wire short_ok = !busy_flag && (cnt == CMD_BITS);

  assign regs_live = {dummy_count, 2'h0, protect_from_bottom,
                      drive_strength, status_lock, quad_io_select, protect_level,
                      write_latch_flag, busy_flag};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_flag <= 1'b0;
      busy_cnt <= '0;
      write_latch_flag <= 1'b0;
      protect_level <= LEVEL_RST;
      status_lock <= 1'b0;
      quad_io_select <= 1'b0;
      protect_from_bottom <= 1'b0;
      drive_strength <= DRIVE_RST;
      dummy_count <= DUMMY_RST;
      four_wire_command_mode <= 1'b0;
    end else if (clk_en) begin
      if (busy_flag) begin
        if (busy_cnt == '0) begin
          busy_flag <= 1'b0;
          write_latch_flag <= 1'b0;
        end else begin
          busy_cnt <= busy_cnt - 1'b1;
        end
      end
      if (frame_end) begin
        if (short_ok && cmd == WRITE_ENABLE_CMD) write_latch_flag <= 1'b1;
        if (short_ok && cmd == WRITE_DISABLE_CMD) write_latch_flag <= 1'b0;
        if (short_ok && cmd == ENTER_FOUR_WIRE_CMD) four_wire_command_mode <= 1'b1;
        if (short_ok && cmd == EXIT_FOUR_WIRE_CMD) four_wire_command_mode <= 1'b0;
        if (wsr_ok) begin
          status_lock <= s_byte[LOCK_BIT];
          quad_io_select <= s_byte[QUAD_BIT];
          protect_level <= s_byte[LEVEL_LSB +: 4];
          busy_flag <= 1'b1;
          busy_cnt <= WRITE_REG_CYC;
          if (two) begin
            drive_strength <= c_byte[DRIVE_LSB +: 3];
            protect_from_bottom <= protect_from_bottom | c_byte[TB_BIT];
            dummy_count <= c_byte[DUMMY_LSB +: 2];
          end
        end
        if (prog_ok) begin
          busy_flag <= 1'b1;
          busy_cnt <= PROGRAM_CYC;
        end
        if (wipe_ok || chip_ok) begin
          busy_flag <= 1'b1;
          busy_cnt <= ERASE_CYC;
        end
      end
    end
  end

  // derived views
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dummy_clocks <= dummy_clocks_of(DUMMY_RST);
      hardware_lock_mode <= 1'b0;
    end else if (clk_en) begin
      dummy_clocks <= dummy_clocks_of(dummy_count);
      hardware_lock_mode <= hw_lock;
    end
  end
endmodule

// [verilog/fsc_host.sv]
`timescale 1ns/1ns
module fsc_host
  import fsc_pkg::*;
#(
  parameter int HALF = SCLK_HALF_CYC
) (
  // system
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // link
  fsc_link_if.host link,
  // request
  input wire logic req_valid,
  input wire logic [7:0] req_op,
  input wire logic [2:0] req_tx_len,
  input wire logic [31:0] req_tx_data,
  input wire logic [3:0] req_rx_len,
  input wire logic four_wire,
  input wire logic wp_level,
  output logic req_ready,
  // answer
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic latch_stuck
);
  typedef enum logic [1:0] {FSC_IDLE, FSC_XFER, FSC_GAP} fsc_state_t;
  localparam int DIV_W = $clog2(HALF * GAP_HALVES + 1);
  localparam logic [DIV_W-1:0] HALF_END = DIV_W'(HALF - 1);
  localparam logic [DIV_W-1:0] GAP_END = DIV_W'(HALF * GAP_HALVES - 1);

  fsc_state_t st;
  logic [DIV_W-1:0] div;
  logic [7:0] u_op;
  logic [2:0] u_tx_len;
  logic [31:0] u_tx_data;
  logic [3:0] u_rx_len;
  logic polling;
  logic [7:0] sh_out;
  logic [31:0] tx_buf;
  logic [2:0] tx_left;
  logic [3:0] rx_left;
  logic in_rx;
  logic [2:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [3:0] io_m;
  logic [3:0] io_s;
  logic sclk_r;
  logic cs_r;
  logic [3:0] out_r;
  logic [3:0] oe_r;

  wire guarded = (req_op != READ_STATUS_CMD) && (req_op != READ_CONFIG_CMD);
  wire tick = (div == HALF_END);
  wire [2:0] step = four_wire ? 3'(STEP_QUAD) : 3'(STEP_SINGLE);
  wire [2:0] next_bits = bit_cnt + step;
  wire byte_done = tick && sclk_r && (next_bits == '0);
  wire [7:0] next_rx = four_wire ? {rx_sh[3:0], io_s} : {rx_sh[6:0], io_s[1]};
  wire still_busy = rx_sh[BUSY_BIT];
  wire latch_on = rx_sh[LATCH_BIT];
  wire [3:0] drv = four_wire ? sh_out[7:4] : {1'b1, wp_level, 1'b0, sh_out[7]};
  // let go of the lanes once the last command edge is taken, before the device turns them
  wire turn = !in_rx && (tx_left == '0) && (rx_left != '0) && (next_bits == '0) && sclk_r;
  wire [3:0] drv_oe = (in_rx || turn) ? (four_wire ? 4'h0 : HOST_RX_SINGLE) :
                      (four_wire ? LANES_QUAD : HOST_TX_SINGLE);

  assign link.sclk = sclk_r;
  assign link.cs_n = cs_r;
  assign link.host_io_out = out_r;
  assign link.host_io_oe = oe_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_m <= '0;
      io_s <= '0;
      out_r <= '0;
      oe_r <= '0;
    end else if (clk_en) begin
      io_m <= link.io;
      io_s <= io_m;
      out_r <= (st == FSC_XFER) ? drv : {1'b1, wp_level, 2'h0};
      oe_r <= (st == FSC_XFER) ? drv_oe : HOST_RX_SINGLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= FSC_IDLE;
      div <= '0;
      {u_op, u_tx_len, u_tx_data, u_rx_len} <= '0;
      {polling, sh_out, tx_buf, tx_left, rx_left, in_rx, bit_cnt, rx_sh} <= '0;
      sclk_r <= 1'b0;
      cs_r <= 1'b1;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      latch_stuck <= 1'b0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      unique case (st)
        FSC_IDLE: begin
          req_ready <= !req_valid;
          div <= '0;
          if (req_valid) begin
            {u_op, u_tx_len, u_tx_data, u_rx_len} <=
              {req_op, req_tx_len, req_tx_data, req_rx_len};
            polling <= guarded;
            sh_out <= guarded ? READ_STATUS_CMD : req_op;
            tx_buf <= req_tx_data;
            tx_left <= guarded ? 3'h0 : req_tx_len;
            rx_left <= guarded ? 4'h1 : req_rx_len;
            {in_rx, bit_cnt} <= '0;
            cs_r <= 1'b0;
            st <= FSC_XFER;
          end
        end
        FSC_XFER: begin
          div <= tick ? '0 : div + 1'b1;
          if (tick && !sclk_r) begin
            sclk_r <= 1'b1;
            rx_sh <= next_rx;
          end
          if (tick && sclk_r) begin
            sclk_r <= 1'b0;
            bit_cnt <= next_bits;
            sh_out <= four_wire ? (sh_out << STEP_QUAD) : (sh_out << STEP_SINGLE);
          end
          if (byte_done) begin
            if (in_rx && !polling) begin
              rsp_valid <= 1'b1;
              rsp_data <= rx_sh;
            end
            if (!in_rx && tx_left != '0) begin
              sh_out <= tx_buf[31:24];
              tx_buf <= tx_buf << 8;
              tx_left <= tx_left - 1'b1;
            end else if (!in_rx && rx_left != '0) begin
              in_rx <= 1'b1;
            end else if (in_rx && rx_left > 4'h1) begin
              rx_left <= rx_left - 1'b1;
            end else begin
              cs_r <= 1'b1;
              div <= '0;
              st <= FSC_GAP;
            end
          end
        end
        FSC_GAP: begin
          div <= div + 1'b1;
          if (div == GAP_END) begin
            div <= '0;
            {in_rx, bit_cnt} <= '0;
            if (polling && still_busy) begin
              cs_r <= 1'b0;
              st <= FSC_XFER;
            end else if (polling) begin
              latch_stuck <= (u_op == WRITE_ENABLE_CMD) && latch_on;
              polling <= 1'b0;
              sh_out <= u_op;
              tx_buf <= u_tx_data;
              tx_left <= u_tx_len;
              rx_left <= u_rx_len;
              cs_r <= 1'b0;
              st <= FSC_XFER;
            end else begin
              st <= FSC_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule

// [verif/fsc_link_props.sv]
`timescale 1ns/1ns
module fsc_link_props
  import fsc_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst_b,
  // link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_out,
  input wire logic [3:0] dev_io_oe
);
  logic sclk_q;
  logic [5:0] rises;
  wire [3:0] dev_drive = dev_io_out & dev_io_oe;
  wire new_rise = sclk & ~sclk_q & (rises != 6'h3F);

  // counts rising link clocks in the current frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      rises <= 6'h00;
    end else begin
      sclk_q <= sclk;
      rises <= cs_n ? 6'h00 : rises + {5'h00, new_rise};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_no_contention: assert property ((host_io_oe & dev_io_oe) == 4'h0)
    else $error("both ends drive io");
  a_lanes_legal: assert property (dev_io_oe == 4'h0 || dev_io_oe == LANES_SINGLE_RD ||
    dev_io_oe == LANES_QUAD) else $error("device drives odd lanes");
  a_quiet_deselect: assert property (cs_n && $past(cs_n) |-> dev_io_oe == 4'h0)
    else $error("device drives while deselected");
  a_sclk_idle: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("link clock runs outside frame");
  a_deselect_gap: assert property ($rose(cs_n) |-> cs_n [*5])
    else $error("deselect too short");
  a_single_turn: assert property ($rose(dev_io_oe[1]) && !dev_io_oe[0] |-> rises == 6'h08)
    else $error("single read starts at wrong clock");
  a_quad_turn: assert property ($rose(dev_io_oe[0]) |-> rises == 6'h02)
    else $error("quad read starts at wrong clock");
  a_shift_on_low: assert property (!cs_n && !$past(cs_n) && $changed(dev_drive) |-> !sclk)
    else $error("output changed with link clock high");
  a_read_stands: assert property (dev_io_oe != 4'h0 && !cs_n |=> cs_n || $stable(dev_io_oe))
    else $error("read output dropped in frame");

  c_single: cover property ($rose(dev_io_oe[1]) && !dev_io_oe[0]);
  c_quad: cover property ($rose(dev_io_oe[0]));
  c_frame_end: cover property ($rose(cs_n));
endmodule

// [verif/test_flash_status_config_regs.sv]
`timescale 1ns/1ns
module test_flash_status_config_regs
  import fsc_pkg::*;
;
  logic clk, rst_b, req_valid, four_wire, wp_level, req_ready, rsp_valid, latch_stuck;
  logic [7:0] req_op, rsp_data;
  logic [2:0] req_tx_len, drive_strength;
  logic [31:0] req_tx_data;
  logic [3:0] req_rx_len, protect_level, dummy_clocks;
  logic busy_flag, write_latch_flag, quad_io_select, status_lock, protect_from_bottom;
  logic four_wire_command_mode, hardware_lock_mode;
  logic [1:0] dummy_count;
  logic [7:0] rx [0:15];
  logic [3:0] dtab [0:3] = '{4'h8, 4'h6, 4'h8, 4'hA};
  int num_errors = 0;
  int checked = 0;

  fsc_link_if fsc_link_if_i();
  fsc_host #(.HALF(4)) fsc_host_i(.clk(clk), .rst_b(rst_b), .clk_en(1'b1),
    .link(fsc_link_if_i), .req_valid(req_valid), .req_op(req_op), .req_tx_len(req_tx_len),
    .req_tx_data(req_tx_data), .req_rx_len(req_rx_len), .four_wire(four_wire),
    .wp_level(wp_level), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .latch_stuck(latch_stuck));
  fsc_device fsc_device_i(.clk(clk), .rst_b(rst_b), .clk_en(1'b1), .link(fsc_link_if_i),
    .busy_flag(busy_flag), .write_latch_flag(write_latch_flag), .protect_level(protect_level),
    .quad_io_select(quad_io_select), .status_lock(status_lock),
    .protect_from_bottom(protect_from_bottom), .drive_strength(drive_strength),
    .dummy_count(dummy_count), .dummy_clocks(dummy_clocks),
    .four_wire_command_mode(four_wire_command_mode), .hardware_lock_mode(hardware_lock_mode));
  fsc_link_props fsc_link_props_i(.clk(clk), .rst_b(rst_b), .sclk(fsc_link_if_i.sclk),
    .cs_n(fsc_link_if_i.cs_n), .host_io_oe(fsc_link_if_i.host_io_oe),
    .dev_io_out(fsc_link_if_i.dev_io_out), .dev_io_oe(fsc_link_if_i.dev_io_oe));

  initial begin
    clk = 1'b0;
    forever #(CLK_NS / 2) clk = ~clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wait_ready(inout int t);
    while (req_ready !== 1'b1 && t < 30000) begin
      @(posedge clk);
      #1;
      t++;
    end
  endtask

  // one host request; read bytes land in rx
  task automatic xfer(input logic [7:0] op, input logic [2:0] n, input logic [31:0] d,
                      input logic [3:0] rn);
    int t;
    int k;
    t = 0;
    k = 0;
    wait_ready(t);
    req_op = op;
    req_tx_len = n;
    req_tx_data = d;
    req_rx_len = rn;
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    while (k < rn && t < 30000) begin
      @(posedge clk);
      #1;
      t++;
      if (rsp_valid === 1'b1) begin
        rx[k] = rsp_data;
        k++;
      end
    end
    wait_ready(t);
    chk(8'(k), {4'h0, rn});
    chk({7'h00, t < 30000}, 8'h01);
  endtask

  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    xfer(op, 3'h0, 32'h0, 4'h1);
    chk(rx[0], exp);
  endtask

  task automatic poll_idle;
    for (int i = 0; i < 40; i++) begin
      xfer(READ_STATUS_CMD, 3'h0, 32'h0, 4'h1);
      if (rx[0][BUSY_BIT] === 1'b0) break;
    end
  endtask

  task automatic wsr(input logic [7:0] s, input logic [7:0] c);
    xfer(WRITE_ENABLE_CMD, 3'h0, 32'h0, 4'h0);
    xfer(WRITE_STATUS_CMD, 3'h2, {s, c, 16'h0000}, 4'h0);
    poll_idle();
  endtask

  initial begin
    #400000;
    num_errors++;
    end_of_test();
  end

  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_op = 8'h00;
    req_tx_len = 3'h0;
    req_tx_data = 32'h0;
    req_rx_len = 4'h0;
    four_wire = 1'b0;
    wp_level = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    @(posedge clk);
    #1;
    xfer(READ_STATUS_CMD, 3'h0, 32'h0, 4'h2);
    chk(rx[0], 8'h00);
    chk(rx[1], 8'h00);
    rd(READ_CONFIG_CMD, 8'h07);
    chk({4'h0, dummy_clocks}, 8'h08);
    $display("test reset values done");
    xfer(WRITE_STATUS_CMD, 3'h2, 32'h0C45_0000, 4'h0);
    rd(READ_STATUS_CMD, 8'h00);
    xfer(WRITE_ENABLE_CMD, 3'h0, 32'h0, 4'h0);
    rd(READ_STATUS_CMD, 8'h02);
    xfer(WRITE_STATUS_CMD, 3'h2, 32'h0C45_0000, 4'h0);
    xfer(READ_STATUS_CMD, 3'h0, 32'h0, 4'h1);
    chk(rx[0] & 8'h03, 8'h03);
    xfer(READ_CONFIG_CMD, 3'h0, 32'h0, 4'h1);
    poll_idle();
    rd(READ_STATUS_CMD, 8'h0C);
    rd(READ_CONFIG_CMD, 8'h45);
    chk({4'h0, protect_level}, 8'h03);
    chk({status_lock, quad_io_select, protect_level, write_latch_flag, busy_flag}, 8'h0C);
    chk({dummy_count, 3'h0, drive_strength}, 8'h45);
    for (int i = 0; i < 4; i++) begin
      wsr(8'h0C, {i[1:0], 6'h07});
      rd(READ_CONFIG_CMD, {i[1:0], 6'h07});
      chk({4'h0, dummy_clocks}, {4'h0, dtab[i]});
    end
    $display("test status write done");
    xfer(WRITE_ENABLE_CMD, 3'h0, 32'h0, 4'h0);
    xfer(CHIP_WIPE_CMD, 3'h0, 32'h0, 4'h0);
    rd(READ_STATUS_CMD, 8'h0E);
    xfer(PAGE_WRITE_CMD, 3'h4, 32'hFF00_005A, 4'h0);
    rd(READ_STATUS_CMD, 8'h0E);
    xfer(PAGE_WRITE_CMD, 3'h4, 32'h0000_005A, 4'h0);
    rd(READ_STATUS_CMD, 8'h0F);
    poll_idle();
    rd(READ_STATUS_CMD, 8'h0C);
    $display("test protection done");
    wp_level = 1'b0;
    wsr(8'h8C, 8'hC7);
    rd(READ_STATUS_CMD, 8'h8C);
    chk({7'h00, hardware_lock_mode}, 8'h01);
    wsr(8'h00, 8'hC7);
    rd(READ_STATUS_CMD, 8'h8E);
    xfer(WRITE_ENABLE_CMD, 3'h0, 32'h0, 4'h0);
    chk({7'h00, latch_stuck}, 8'h01);
    xfer(WRITE_DISABLE_CMD, 3'h0, 32'h0, 4'h0);
    chk({7'h00, latch_stuck}, 8'h00);
    wp_level = 1'b1;
    wsr(8'hC0, 8'hC7);
    wp_level = 1'b0;
    rd(READ_STATUS_CMD, 8'hC0);
    chk({6'h00, quad_io_select, hardware_lock_mode}, 8'h02);
    wsr(8'h00, 8'hC7);
    rd(READ_STATUS_CMD, 8'h00);
    $display("test lock done");
    wsr(8'h00, 8'hCD);
    rd(READ_CONFIG_CMD, 8'hCD);
    chk({7'h00, protect_from_bottom}, 8'h01);
    wsr(8'h00, 8'hC7);
    rd(READ_CONFIG_CMD, 8'hCF);
    $display("test top bottom done");
    xfer(ENTER_FOUR_WIRE_CMD, 3'h0, 32'h0, 4'h0);
    four_wire = 1'b1;
    rd(READ_STATUS_CMD, 8'h00);
    rd(READ_CONFIG_CMD, 8'hCF);
    chk({7'h00, four_wire_command_mode}, 8'h01);
    xfer(EXIT_FOUR_WIRE_CMD, 3'h0, 32'h0, 4'h0);
    four_wire = 1'b0;
    rd(READ_STATUS_CMD, 8'h00);
    $display("test four wire done");
    end_of_test();
  end
endmodule
